// File: pma_defs.svh
`ifndef PMA_DEFS_SVH
`define PMA_DEFS_SVH

// Register byte offsets
`define PMA_ADDR_CNT0 8'h00
`define PMA_ADDR_CNT1 8'h04
`define PMA_ADDR_CNT2 8'h08
`define PMA_ADDR_CNT3 8'h0c
`define PMA_ADDR_CNT4 8'h10
`define PMA_ADDR_STATUS 8'h14
`define PMA_ADDR_CTRL 8'h18
`define PMA_ADDR_MID 8'h1c
`define PMA_ADDR_OVF 8'h20
`define PMA_ADDR_VETO 8'h24
`define PMA_ADDR_PILE 8'h28
`define PMA_ADDR_LOST 8'h2c

// Field positions
`define PMA_CTRL_EN_BIT 0
`define PMA_HALF_BIT 4
`define PMA_TGRP_HALF_BIT 5
`define PMA_TEST_LSB 6
`define PMA_TEST_MSB 11
`define PMA_MID_LSB 4
`define PMA_MID_MSB 11

// Reset values
`define PMA_CTRL_EN_RST 1'b1

// Timing
`define PMA_CLK_MHZ 250
`define PMA_GATE_TIME_MS 3890
`define PMA_GATE_CYCLES (`PMA_GATE_TIME_MS * `PMA_CLK_MHZ * 1000)

`endif

// File: pma_pkg.sv
package pma_pkg;

	typedef enum logic [3:0] {
		PMA_MODE_A = 4'h0,
		PMA_MODE_B = 4'h1,
		PMA_MODE_C = 4'h2,
		PMA_MODE_D = 4'h3,
		PMA_MODE_E = 4'h4,
		PMA_MODE_F = 4'h5,
		PMA_MODE_G = 4'h6,
		PMA_MODE_H = 4'h7,
		PMA_MODE_I = 4'h8
	} pma_mode_t;

	typedef struct packed {
		logic frame_frz;
		logic burst_frz;
		logic [11:0] seq;
		logic pileup;
		logic strobe;
		logic [4:0] pha;
		logic e4_hi;
		logic e4_lo;
		logic [5:0] det;
	} pma_pins_t;

	typedef struct packed {
		pma_pins_t sy1;
		pma_pins_t sy2;
		logic strobe_d;
		logic seq0_d;
		logic settle;
		logic primed;
		logic [11:0] seq_hold;
		pma_mode_t mode;
		logic [5:0] req;
		logic [5:0] veto;
		logic [1:0] gain;
		logic pileup_en;
		logic long_test;
		logic cal_ext;
		logic inject;
		logic frame_frz_d;
		logic [31:0] gate_cnt;
		logic gate_on;
		logic ctrl_en;
		logic [4:0][15:0] cnt;
		logic [4:0] ovf;
		logic [15:0] veto_cnt;
		logic [15:0] pile_cnt;
		logic [15:0] lost_cnt;
		logic [7:0] mid;
		logic [31:0] rdata;
	} pma_state_t;

endpackage : pma_pkg

// File: pma_accumulator.sv
// What this block does
// - Qualified modes count only events passing coincidence and veto; singles mode counts detectors 2-6.
// - Modes C through H reject any event with a detector six pulse.
// - Modes C to F ignore detector one, and sometimes detector two or three.
// - Mode H rejects any event with a detector three pulse.
// - Mode G accepts only when detector four energy is inside the low/high window.
// - Summed pulse height picks one of five channels, each with a 16-bit counter.
// - Coincidence requirements and linear gate gain follow the selected mode.
// - One mode holds for a whole telemetry sequence; counting uses only its conditions, but the masks switch two cycles after the counters clear.
// - At each sequence end advance mode, clear all five counters, restart counting.
// - Mode sequencing comes from the telemetry sequence clock lines.
// - A full mode cycle spans 32 sequences with unequal mode weights.
// - The two 16-sequence halves differ only in pileup rejector enable.
// - Lines six to eleven all high raise the long test signal for 64 sequences.
// - Half of the test group extends the calibration source.
// - Other half of the test group injects internal test pulses.
// - All five counters are read once per sequence at its end, burst half.
// - During end-of-sequence readout the five channel counters stop and hold.
// - Middle eight bits of counter one are read once per frame, blank half.
// - Counter gating totals 3.89 s in each 5.12 s sequence.
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pma_defs.svh"
module pma_accumulator import pma_pkg::*; #(
	parameter int unsigned GATE_CYCLES = `PMA_GATE_CYCLES // Gated span per sequence
) (
	input wire logic clk_sys, // System clock
	input wire logic rst_n, // Async reset, active low
	input wire logic [5:0] det_hit, // Discriminators, bit0 = detector one
	input wire logic e4_above_low, // Detector four above lower level
	input wire logic e4_above_high, // Detector four above upper level
	input wire logic [4:0] pha_level, // Sum pulse above each channel threshold
	input wire logic event_strobe, // Pulse analysis ready
	input wire logic pileup_seen, // Pileup detector output
	input wire logic [11:0] seq_line, // Telemetry sequence clock lines
	input wire logic burst_freeze, // Burst readout in progress
	input wire logic frame_freeze, // Partial readout words
	input wire logic [7:0] reg_addr, // Register byte address
	input wire logic [31:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [31:0] reg_rdata, // Read data, cycle after strobe
	output logic [3:0] mode_code, // Active mode
	output logic [1:0] gain_sel, // Linear gate gain
	output logic [5:0] coin_require, // Coincidence mask
	output logic [5:0] coin_veto, // Anti-coincidence mask
	output logic pileup_enable, // Pileup rejector on
	output logic long_test, // Long-period test group
	output logic cal_extend, // Calibration source out
	output logic test_inject, // Internal test pulses on
	output logic [7:0] mid_bits // Counter one middle bits
);

	pma_state_t r;
	pma_state_t n;
	pma_pins_t pins;
	logic seq_edge;
	logic strobe_rise;
	logic frozen;
	logic countable;
	logic pass;
	logic window_ok;
	logic pile_rej;
	logic any_bin;
	logic [2:0] bin;
	logic wr_ovf;
	logic [4:0] inc;
	logic [4:0] ovf_set;
	logic [15:0] status;

	// Weighted toward electron and low energy proton modes
	function automatic pma_mode_t mode_lut(input logic [3:0] idx);
		case (idx)
			4'h0: mode_lut = PMA_MODE_A;
			4'h1: mode_lut = PMA_MODE_G;
			4'h2: mode_lut = PMA_MODE_H;
			4'h3: mode_lut = PMA_MODE_B;
			4'h4: mode_lut = PMA_MODE_G;
			4'h5: mode_lut = PMA_MODE_H;
			4'h6: mode_lut = PMA_MODE_C;
			4'h7: mode_lut = PMA_MODE_A;
			4'h8: mode_lut = PMA_MODE_G;
			4'h9: mode_lut = PMA_MODE_H;
			4'ha: mode_lut = PMA_MODE_D;
			4'hb: mode_lut = PMA_MODE_E;
			4'hc: mode_lut = PMA_MODE_G;
			4'hd: mode_lut = PMA_MODE_H;
			4'he: mode_lut = PMA_MODE_F;
			4'hf: mode_lut = PMA_MODE_I;
			default: mode_lut = PMA_MODE_A;
		endcase
	endfunction : mode_lut

	// Bit0 is detector one; a detector in neither mask is ignored
	function automatic logic [5:0] req_lut(input pma_mode_t m);
		case (m)
			PMA_MODE_A: req_lut = 6'h01;
			PMA_MODE_B: req_lut = 6'h03;
			PMA_MODE_C: req_lut = 6'h06;
			PMA_MODE_D: req_lut = 6'h0c;
			PMA_MODE_E: req_lut = 6'h18;
			PMA_MODE_F: req_lut = 6'h18;
			PMA_MODE_G: req_lut = 6'h18;
			PMA_MODE_H: req_lut = 6'h08;
			default: req_lut = 6'h00;
		endcase
	endfunction : req_lut

	function automatic logic [5:0] veto_lut(input pma_mode_t m);
		case (m)
			PMA_MODE_A: veto_lut = 6'h02;
			PMA_MODE_B: veto_lut = 6'h04;
			PMA_MODE_C: veto_lut = 6'h28;
			PMA_MODE_D: veto_lut = 6'h30;
			PMA_MODE_E: veto_lut = 6'h20;
			PMA_MODE_F: veto_lut = 6'h20;
			PMA_MODE_G: veto_lut = 6'h20;
			PMA_MODE_H: veto_lut = 6'h34;
			default: veto_lut = 6'h00;
		endcase
	endfunction : veto_lut

	function automatic logic [1:0] gain_lut(input pma_mode_t m);
		case (m)
			PMA_MODE_A, PMA_MODE_B: gain_lut = 2'h0;
			PMA_MODE_C, PMA_MODE_D: gain_lut = 2'h1;
			PMA_MODE_E, PMA_MODE_F: gain_lut = 2'h2;
			default: gain_lut = 2'h3;
		endcase
	endfunction : gain_lut

	assign pins = '{
		frame_frz: frame_freeze,
		burst_frz: burst_freeze,
		seq: seq_line,
		pileup: pileup_seen,
		strobe: event_strobe,
		pha: pha_level,
		e4_hi: e4_above_high,
		e4_lo: e4_above_low,
		det: det_hit
	};

	always_comb begin
		n = r;
		n.sy1 = pins;
		n.sy2 = r.sy1;
		n.strobe_d = r.sy2.strobe;
		n.seq0_d = r.sy2.seq[0];
		n.frame_frz_d = r.sy2.frame_frz;
		n.rdata = 32'h0000_0000;
		inc = 5'h00;
		ovf_set = 5'h00;
		bin = 3'h0;
		any_bin = 1'b0;

		seq_edge = r.sy2.seq[0] ^ r.seq0_d;
		n.settle = seq_edge;
		n.primed = 1'b1;
		strobe_rise = r.sy2.strobe & ~r.strobe_d;

		// snapshot one cycle after the edge, so line skew cannot leak in
		if (r.settle || !r.primed) begin
			n.seq_hold = r.sy2.seq;
		end

		// mode fixed by held sequence bits
		n.mode = mode_lut(r.seq_hold[3:0]);
		n.req = req_lut(r.mode);
		n.veto = veto_lut(r.mode);
		n.gain = gain_lut(r.mode);
		// low bits repeat every 32 sequences
		n.pileup_en = r.seq_hold[`PMA_HALF_BIT];
		n.long_test = &r.seq_hold[`PMA_TEST_MSB:`PMA_TEST_LSB];
		n.cal_ext = n.long_test & ~r.seq_hold[`PMA_TGRP_HALF_BIT];
		n.inject = n.long_test & r.seq_hold[`PMA_TGRP_HALF_BIT];

		// gate window counted from sequence start
		if (r.settle) begin
			n.gate_cnt = 32'h0000_0000;
			n.gate_on = 1'b1;
		end else if (r.gate_on) begin
			n.gate_cnt = r.gate_cnt + 32'h0000_0001;
			if (r.gate_cnt >= GATE_CYCLES - 32'h0000_0001) begin
				n.gate_on = 1'b0;
			end
		end

		frozen = r.sy2.burst_frz | r.sy2.frame_frz;
		countable = r.ctrl_en & r.gate_on & ~frozen & ~r.settle;

		pass = ((r.sy2.det & r.req) == r.req) && ((r.sy2.det & r.veto) == 6'h00);

		case (r.mode)
			PMA_MODE_G: window_ok = r.sy2.e4_lo & ~r.sy2.e4_hi;
			PMA_MODE_F: window_ok = r.sy2.e4_hi;
			default: window_ok = 1'b1;
		endcase
		pile_rej = r.pileup_en & r.sy2.pileup;

		for (int i = 0; i < 5; i++) begin
			if (r.sy2.pha[i]) begin
				bin = 3'(i);
				any_bin = 1'b1;
			end
		end

		// an event that cannot be counted only bumps the lost counter, while enabled
		if (strobe_rise && !countable && r.ctrl_en) begin
			if (r.lost_cnt != 16'hffff) begin
				n.lost_cnt = r.lost_cnt + 16'h0001;
			end
		end else if (strobe_rise && countable) begin
			if (r.mode == PMA_MODE_I) begin
				// singles of detectors two to six
				inc = r.sy2.det[5:1];
			end else if (pile_rej) begin
				if (r.pile_cnt != 16'hffff) begin
					n.pile_cnt = r.pile_cnt + 16'h0001;
				end
			end else if (pass && window_ok && any_bin) begin
				inc[bin] = 1'b1;
			end else if (r.veto_cnt != 16'hffff) begin
				n.veto_cnt = r.veto_cnt + 16'h0001;
			end
		end

		for (int i = 0; i < 5; i++) begin
			if (r.settle) begin
				n.cnt[i] = 16'h0000;
			end else if (inc[i]) begin
				n.cnt[i] = r.cnt[i] + 16'h0001;
				ovf_set[i] = (r.cnt[i] == 16'hffff);
			end
		end
		if (r.settle) begin
			n.veto_cnt = 16'h0000;
			n.pile_cnt = 16'h0000;
			n.lost_cnt = 16'h0000;
		end

		// capture middle bits as partial readout opens
		if (r.sy2.frame_frz && !r.frame_frz_d) begin
			n.mid = r.cnt[0][`PMA_MID_MSB:`PMA_MID_LSB];
		end

		// Overflow flags: write one to clear, a new overflow wins
		wr_ovf = reg_wr && (reg_addr == `PMA_ADDR_OVF);
		n.ovf = (r.ovf & ~(wr_ovf ? reg_wdata[4:0] : 5'h00)) | ovf_set;
		if (reg_wr && reg_addr == `PMA_ADDR_CTRL) begin
			n.ctrl_en = reg_wdata[`PMA_CTRL_EN_BIT];
		end

		status = {
			r.seq_hold[5:4],
			r.gate_on,
			frozen,
			r.inject,
			r.cal_ext,
			r.long_test,
			r.pileup_en,
			4'h0,
			r.mode
		};

		// counters readable while burst freeze holds them
		if (reg_rd) begin
			case (reg_addr)
				`PMA_ADDR_CNT0: n.rdata = {16'h0000, r.cnt[0]};
				`PMA_ADDR_CNT1: n.rdata = {16'h0000, r.cnt[1]};
				`PMA_ADDR_CNT2: n.rdata = {16'h0000, r.cnt[2]};
				`PMA_ADDR_CNT3: n.rdata = {16'h0000, r.cnt[3]};
				`PMA_ADDR_CNT4: n.rdata = {16'h0000, r.cnt[4]};
				`PMA_ADDR_STATUS: n.rdata = {16'h0000, status};
				`PMA_ADDR_CTRL: n.rdata = {31'h0000_0000, r.ctrl_en};
				`PMA_ADDR_MID: n.rdata = {24'h00_0000, r.mid};
				`PMA_ADDR_OVF: n.rdata = {27'h000_0000, r.ovf};
				`PMA_ADDR_VETO: n.rdata = {16'h0000, r.veto_cnt};
				`PMA_ADDR_PILE: n.rdata = {16'h0000, r.pile_cnt};
				`PMA_ADDR_LOST: n.rdata = {16'h0000, r.lost_cnt};
				default: n.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.ctrl_en <= `PMA_CTRL_EN_RST;
		end else begin
			r <= n;
		end
	end

	assign reg_rdata = r.rdata;
	assign mode_code = r.mode;
	assign gain_sel = r.gain;
	assign coin_require = r.req;
	assign coin_veto = r.veto;
	assign pileup_enable = r.pileup_en;
	assign long_test = r.long_test;
	assign cal_extend = r.cal_ext;
	assign test_inject = r.inject;
	assign mid_bits = r.mid;

endmodule : pma_accumulator
`default_nettype wire

// File: pma_accumulator_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pma_accumulator_checker (
	input wire logic clk_sys, // Clock
	input wire logic rst_n, // Reset
	input wire logic [11:0] seq_line, // Lines
	input wire logic frame_freeze, // Frame freeze
	input wire logic reg_rd, // Read strobe
	input wire logic [31:0] reg_rdata, // Read data
	input wire logic [3:0] mode_code, // Mode
	input wire logic [1:0] gain_sel, // Gain
	input wire logic [5:0] coin_require, // Req
	input wire logic [5:0] coin_veto, // Veto
	input wire logic pileup_enable, // Pileup
	input wire logic long_test, // Group
	input wire logic cal_extend, // Source
	input wire logic test_inject, // Inject
	input wire logic [7:0] mid_bits // Mid
);
	logic [1:0] up;
	logic [13:0] exp_m;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	function automatic logic [13:0] mk(input logic [3:0] m);
		case (m)
			4'h0: mk = 14'h0042;
			4'h1: mk = 14'h00c4;
			4'h2: mk = 14'h11a8;
			4'h3: mk = 14'h1330;
			4'h4, 4'h5: mk = 14'h2620;
			4'h6: mk = 14'h3620;
			4'h7: mk = 14'h3234;
			default: mk = 14'h3000;
		endcase
	endfunction : mk
	assign exp_m = mk(mode_code);
	// Masks lag reset release, so wait
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			up <= 2'h0;
		end else if (up != 2'h3) begin
			up <= up + 2'h1;
		end
	end
	property p_gain;
		up == 2'h3 && $stable(mode_code) |-> gain_sel == exp_m[13:12];
	endproperty
	a_gain: assert property (p_gain) else $error("gain differs from mode");
	property p_req;
		up == 2'h3 && $stable(mode_code) |-> coin_require == exp_m[11:6];
	endproperty
	a_req: assert property (p_req) else $error("coincidence mask wrong");
	property p_veto;
		up == 2'h3 && $stable(mode_code) |-> coin_veto == exp_m[5:0];
	endproperty
	a_veto: assert property (p_veto) else $error("veto mask wrong");
	property p_range;
		mode_code <= 4'h8;
	endproperty
	a_range: assert property (p_range) else $error("mode out of range");
	property p_mode_hold;
		$changed(mode_code) |-> $past(seq_line[0], 1) != $past(seq_line[0], 8);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode moved mid sequence");
	property p_pile_hold;
		$changed(pileup_enable) |-> $past(seq_line[0], 1) != $past(seq_line[0], 8);
	endproperty
	a_pile_hold: assert property (p_pile_hold) else $error("pileup moved mid sequence");
	property p_group;
		up == 2'h3 && $stable(long_test) |-> (cal_extend | test_inject) == long_test && !(cal_extend && test_inject);
	endproperty
	a_group: assert property (p_group) else $error("test group halves wrong");
	property p_mid;
		$changed(mid_bits) |-> frame_freeze && !$past(frame_freeze, 8);
	endproperty
	a_mid: assert property (p_mid) else $error("mid bits moved off frame");
	property p_rdata;
		!$past(reg_rd) |-> reg_rdata == 32'h0;
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data outside slot");
endmodule : pma_accumulator_checker
bind pma_accumulator pma_accumulator_checker u_chk (.*);
`default_nettype wire

// File: pma_telemetry_model.sv
`timescale 1ns/1ps
`default_nettype none
module pma_telemetry_model (
	input wire logic clk_sys, // Clock
	input wire logic rst_n, // Reset
	input wire logic step, // Next sequence
	input wire logic jump, // Load jval
	input wire logic [11:0] jval, // Load value
	input wire logic bst_req, // Burst readout
	input wire logic frm_req, // Frame readout
	output logic [11:0] seq_line, // Lines
	output logic burst_freeze, // Burst freeze
	output logic frame_freeze // Frame freeze
);
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			seq_line <= 12'h000;
		end else if (jump) begin
			seq_line <= jval;
		end else if (step) begin
			seq_line <= seq_line + 12'h001;
		end
	end
	// readout windows
	// Reset keeps the freezes low so the block never sees unknown levels
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			burst_freeze <= 1'b0;
			frame_freeze <= 1'b0;
		end else begin
			burst_freeze <= bst_req;
			frame_freeze <= frm_req;
		end
	end
endmodule : pma_telemetry_model
`default_nettype wire

// File: pma_accumulator_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pma_accumulator_tb;
	logic clk_sys = 1'b0, rst_n = 1'b0, e4_above_low = 1'b1, e4_above_high = 1'b0, event_strobe = 1'b0;
	logic pileup_seen = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, step = 1'b0, jump = 1'b0, bst_req = 1'b0, frm_req = 1'b0;
	logic [5:0] det_hit = 6'h00;
	logic [4:0] pha_level = 5'h00;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [11:0] jval = 12'h000;
	logic [11:0] seq_line;
	logic burst_freeze, frame_freeze, pileup_enable, long_test, cal_extend, test_inject;
	logic [31:0] reg_rdata;
	logic [3:0] mode_code;
	logic [1:0] gain_sel;
	logic [5:0] coin_require, coin_veto;
	logic [7:0] mid_bits;
	int fails = 0;
	int compares = 0;
	localparam logic [3:0] LUT [16] = '{4'h0, 4'h6, 4'h7, 4'h1, 4'h6, 4'h7, 4'h2, 4'h0,
		4'h6, 4'h7, 4'h3, 4'h4, 4'h6, 4'h7, 4'h5, 4'h8};
	localparam logic [5:0] REQ [9] = '{6'h01, 6'h03, 6'h06, 6'h0c, 6'h18, 6'h18, 6'h18, 6'h08, 6'h00};
	localparam logic [5:0] VETO [9] = '{6'h02, 6'h04, 6'h28, 6'h30, 6'h20, 6'h20, 6'h20, 6'h34, 6'h00};
	localparam logic [1:0] GAIN [9] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h3};
	pma_accumulator #(.GATE_CYCLES(600)) u_dut (.*);
	pma_telemetry_model u_tm (.*);
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic test_done;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	// Levels settle before the strobe and outlast it
	task automatic ev(input logic [5:0] d, input logic [4:0] p, input logic pl);
		@(posedge clk_sys);
		det_hit <= d;
		pha_level <= p;
		pileup_seen <= pl;
		repeat (2) @(posedge clk_sys);
		event_strobe <= 1'b1;
		repeat (3) @(posedge clk_sys);
		event_strobe <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask : ev
	task automatic sq(input logic j, input logic [11:0] v);
		@(posedge clk_sys);
		step <= !j;
		jump <= j;
		jval <= v;
		@(posedge clk_sys);
		step <= 1'b0;
		jump <= 1'b0;
		repeat (8) @(posedge clk_sys);
		#1;
	endtask : sq
	initial begin
		repeat (20000) @(posedge clk_sys);
		fails++;
		test_done();
	end
	initial begin
		logic [3:0] m;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(8'h18, 32'h1);
		rd(8'h30, 32'h0);
		for (int i = 1; i <= 32; i++) begin
			sq(1'b0, 12'h000);
			m = LUT[i % 16];
			chk(mode_code, m);
			chk(pileup_enable, i[4]);
			chk(coin_require, REQ[m]);
			chk(coin_veto, VETO[m]);
			chk(gain_sel, GAIN[m]);
			rd(8'h08, 32'h0);
			e4_above_high <= (m == 4'h5);
			ev(m == 4'h8 ? 6'h02 : REQ[m], 5'h04, 1'b0);
			ev(REQ[m] | VETO[m], 5'h04, 1'b0);
			ev(m == 4'h8 ? 6'h02 : REQ[m], 5'h04, 1'b1);
			if (m == 4'h6) begin
				e4_above_high <= 1'b1;
				ev(REQ[m], 5'h04, 1'b0);
			end
			rd(m == 4'h8 ? 8'h00 : 8'h08, (m == 4'h8 || !i[4]) ? 32'h2 : 32'h1);
		end
		$display("mode walk done");
		repeat (17) ev(6'h01, 5'h01, 1'b0);
		frm_req <= 1'b1;
		repeat (8) @(posedge clk_sys);
		chk(mid_bits, 8'h01);
		rd(8'h1c, 32'h1);
		ev(6'h01, 5'h01, 1'b0);
		rd(8'h00, 32'h11);
		frm_req <= 1'b0;
		bst_req <= 1'b1;
		repeat (8) @(posedge clk_sys);
		ev(6'h01, 5'h01, 1'b0);
		rd(8'h00, 32'h11);
		bst_req <= 1'b0;
		wr(8'h18, 32'h0);
		ev(6'h01, 5'h01, 1'b0);
		rd(8'h00, 32'h11);
		wr(8'h18, 32'h1);
		repeat (600) @(posedge clk_sys);
		ev(6'h01, 5'h01, 1'b0);
		rd(8'h00, 32'h11);
		rd(8'h2c, 32'h3);
		$display("freeze and gate done");
		sq(1'b1, 12'hfc1);
		chk({long_test, cal_extend, test_inject}, 3'b110);
		sq(1'b1, 12'hfe0);
		chk({long_test, cal_extend, test_inject}, 3'b101);
		sq(1'b1, 12'h001);
		chk(long_test, 1'b0);
		$display("test group done");
		test_done();
	end
endmodule : pma_accumulator_tb
`default_nettype wire
